/* File: rtl/divshift_pkg.sv */
// package: constants and carrier types for the integer divide and shift unit
// Operation
// - divider handles 32/16 and 16/16, signed and unsigned
// - quotient goes to quotient register, remainder to remainder register, always
// - divisor comes from any working register named by the instruction
// - 32-bit dividend from aligned pair, odd register upper, even lower
// - one cycle per divisor bit, same cycle count for both sizes
// - single-bit and multi-bit shifts each finish in one cycle
// - shift amounts up to 15 for right and left shifts
// - shifts read and write working registers only, never memory
// - arithmetic right shift replicates sign bit into upper positions
// - logical right shift fills upper positions with zeros
// - left shift fills lower positions with zeros
package divshift_pkg;

  localparam int unsigned DATA_W      = 16;
  localparam int unsigned REG_IDX_W   = 4;
  localparam int unsigned SHAMT_W     = 4;
  localparam int unsigned DIV_CYCLES  = 16;
  localparam int unsigned CNT_W       = 5;
  localparam logic [3:0]  QUOT_REG    = 4'h0;
  localparam logic [3:0]  REM_REG     = 4'h1;

  typedef enum logic [1:0] {
    SHIFT_ARITH_RIGHT,
    SHIFT_LOGIC_RIGHT,
    SHIFT_LEFT
  } shift_op_e;

  // divide request as issued by the sequencer
  typedef struct packed {
    logic                 wide;
    logic                 signed_op;
    logic [REG_IDX_W-1:0] dividend_reg;
    logic [REG_IDX_W-1:0] divisor_source_register;
  } div_req_s;

  // shift request; dest is always a working register
  typedef struct packed {
    shift_op_e            op;
    logic [SHAMT_W-1:0]   amount;
    logic [REG_IDX_W-1:0] src_reg;
    logic [REG_IDX_W-1:0] dst_reg;
  } shift_req_s;

  // register file write port
  typedef struct packed {
    logic                 en;
    logic [REG_IDX_W-1:0] idx;
    logic [DATA_W-1:0]    data;
  } wr_port_s;

endpackage

/* File: rtl/barrel_shifter.sv */
// barrel shifter: one-cycle single and multi-bit shifts
`timescale 1ns/1ps
`default_nettype none
module barrel_shifter #(
  parameter int unsigned WIDTH = 16
) (
  input  wire logic [WIDTH-1:0]          operand,
  input  wire logic [3:0]                amount,
  input  wire divshift_pkg::shift_op_e   op,
  output logic      [WIDTH-1:0]          result
);

  always_comb begin
    unique case (op)
      divshift_pkg::SHIFT_ARITH_RIGHT: result = $signed(operand) >>> amount;
      divshift_pkg::SHIFT_LOGIC_RIGHT: result = operand >> amount;
      divshift_pkg::SHIFT_LEFT:        result = operand << amount;
      default:                         result = operand;
    endcase
  end

endmodule // barrel_shifter
`default_nettype wire

/* File: rtl/divide_shift_unit.sv */
// integer divide and shift unit with its own working register file
`timescale 1ns/1ps
`default_nettype none
module divide_shift_unit #(
  parameter int unsigned NUM_REGS = 16
) (
  input  wire logic                              core_clk,
  input  wire logic                              reset_n,
  input  wire logic                              div_start,
  input  wire divshift_pkg::div_req_s            div_req,
  output logic                                   div_busy,
  output logic                                   div_done,
  output logic                                   div_by_zero,
  input  wire logic                              shift_start,
  input  wire divshift_pkg::shift_req_s          shift_req,
  output logic                                   shift_done,
  input  wire divshift_pkg::wr_port_s            seq_wr,
  input  wire logic [divshift_pkg::REG_IDX_W-1:0] rd_idx,
  output logic      [divshift_pkg::DATA_W-1:0]    rd_data
);

  localparam int unsigned W = divshift_pkg::DATA_W;

  typedef enum logic [1:0] {IDLE, ITER, FIX, WRITE} div_state_e;

  logic [W-1:0] regs_q [NUM_REGS];

  div_state_e                     state_q;
  logic [31:0]                    num_q;      // lower half of dividend magnitude, shifts out into remainder
  logic [W:0]                     rem_q;
  logic [W-1:0]                   dvs_q;
  logic [W-1:0]                   quo_q;
  logic [divshift_pkg::CNT_W-1:0] cnt_q;
  logic                           neg_q_q;
  logic                           neg_r_q;
  logic                           zero_q;
  logic                           div_take;   // divide accepted at this edge
  logic                           div_last;   // final restoring step
  logic                           div_write;  // results land in the register file

  // two's complement negate, kept to the data width
  function automatic logic [W-1:0] neg16(input logic [W-1:0] v);
    neg16 = W'(-v);
  endfunction

  // magnitude of a word that may be signed
  function automatic logic [W-1:0] mag16(input logic [W-1:0] v, input logic s);
    mag16 = (s && v[W-1]) ? neg16(v) : v;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // operand fetch

  logic [31:0] dividend_raw;
  logic [W-1:0] divisor_raw;
  logic [31:0] dividend_mag;
  logic        dividend_neg;
  logic [divshift_pkg::REG_IDX_W-1:0] even_idx;

  always_comb begin
    even_idx    = {div_req.dividend_reg[divshift_pkg::REG_IDX_W-1:1], 1'b0};
    divisor_raw = regs_q[div_req.divisor_source_register];
    if (div_req.wide) begin
      dividend_raw = {regs_q[even_idx | 4'h1], regs_q[even_idx]};
    end else begin
      dividend_raw = div_req.signed_op ?
                     {{W{regs_q[div_req.dividend_reg][W-1]}}, regs_q[div_req.dividend_reg]} :
                     {16'h0000, regs_q[div_req.dividend_reg]};
    end
    dividend_neg = div_req.signed_op && dividend_raw[31];
    dividend_mag = dividend_neg ? 32'(-dividend_raw) : dividend_raw;
  end

  //////////////////////////////////////////////////////////////////////////////
  // divider control
  // restoring divide: the upper half is preloaded into the remainder so only
  // 16 steps remain, which keeps 32/16 and 16/16 at the same latency; the
  // price is that a quotient wider than 16 bits silently gives a wrong quotient and remainder

  logic [W:0] trial;
  logic [W:0] shifted;
  logic       trial_fits;

  always_comb begin
    shifted    = {rem_q[W-1:0], num_q[31]};
    trial      = shifted - {1'b0, dvs_q};
    // a set top remainder bit means the shifted value exceeds any divisor
    trial_fits = !trial[W] || rem_q[W-1];
    div_take   = div_start && (state_q == IDLE);
    div_last   = (state_q == ITER) && (cnt_q == divshift_pkg::CNT_W'(1));
    div_write  = (state_q == WRITE);
  end

  // sequencing: idle, sixteen steps, sign fix, then result write
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_q <= IDLE;
    end else begin
      unique case (state_q)
        IDLE: begin
          if (div_take) begin
            state_q <= ITER;
          end
        end
        ITER: begin
          if (div_last) begin
            state_q <= FIX;
          end
        end
        FIX: begin
          state_q <= WRITE;
        end
        WRITE: begin
          state_q <= IDLE;
        end
      endcase
    end
  end

  // one step per divisor bit, whatever the dividend width
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else if (div_take) begin
      cnt_q <= divshift_pkg::CNT_W'(divshift_pkg::DIV_CYCLES);
    end else if (state_q == ITER) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // divisor and signs are captured once, so a register write during the
  // divide cannot disturb it
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      dvs_q   <= '0;
      zero_q  <= 1'b0;
      neg_r_q <= 1'b0;
      neg_q_q <= 1'b0;
    end else if (div_take) begin
      dvs_q   <= mag16(divisor_raw, div_req.signed_op);
      zero_q  <= (divisor_raw == 16'h0000);
      neg_r_q <= dividend_neg;
      neg_q_q <= dividend_neg ^ (div_req.signed_op && divisor_raw[W-1]);
    end
  end

  // lower dividend half, fed one bit per step into the remainder
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      num_q <= 32'h0000_0000;
    end else if (div_take) begin
      num_q <= {dividend_mag[15:0], 16'h0000};
    end else if (state_q == ITER) begin
      num_q <= {num_q[30:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rem_q <= '0;
    end else if (div_take) begin
      rem_q <= {1'b0, dividend_mag[31:16]};
    end else if (state_q == ITER) begin
      rem_q <= trial_fits ? {1'b0, trial[W-1:0]} : {1'b0, shifted[W-1:0]};
    end else if (state_q == FIX && neg_r_q) begin
      rem_q <= {1'b0, neg16(rem_q[W-1:0])};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      quo_q <= '0;
    end else if (div_take) begin
      quo_q <= '0;
    end else if (state_q == ITER) begin
      quo_q <= {quo_q[W-2:0], trial_fits};
    end else if (state_q == FIX && neg_q_q) begin
      quo_q <= neg16(quo_q);
    end
  end

  always_comb begin
    div_busy = (state_q != IDLE);
    div_done = div_write;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      div_by_zero <= 1'b0;
    end else if (div_write) begin
      div_by_zero <= zero_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // shifter

  logic [W-1:0] shift_res;

  barrel_shifter #(
    .WIDTH (W)
  ) u_shifter (
    .operand (regs_q[shift_req.src_reg]),
    .amount  (shift_req.amount),
    .op      (shift_req.op),
    .result  (shift_res)
  );

  // shift is refused while a divide owns the result registers
  logic shift_go;
  assign shift_go = shift_start && (state_q == IDLE) && !div_start;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      shift_done <= 1'b0;
    end else begin
      shift_done <= shift_go;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // working register file
  // four writers; the unit's own results are applied last so they win over
  // a sequencer write to the same index in the same cycle

  divshift_pkg::wr_port_s shift_wr;
  divshift_pkg::wr_port_s quot_wr;
  divshift_pkg::wr_port_s rem_wr;

  always_comb begin
    shift_wr.en   = shift_go;
    shift_wr.idx  = shift_req.dst_reg;
    shift_wr.data = shift_res;
    quot_wr.en    = div_write;
    quot_wr.idx   = divshift_pkg::QUOT_REG;
    quot_wr.data  = quo_q;
    rem_wr.en     = div_write;
    rem_wr.idx    = divshift_pkg::REM_REG;
    rem_wr.data   = rem_q[W-1:0];
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_q[i] <= '0;
      end
    end else begin
      if (seq_wr.en) begin
        regs_q[seq_wr.idx] <= seq_wr.data;
      end
      if (shift_wr.en) begin
        regs_q[shift_wr.idx] <= shift_wr.data;
      end
      if (quot_wr.en) begin
        regs_q[quot_wr.idx] <= quot_wr.data;
      end
      if (rem_wr.en) begin
        regs_q[rem_wr.idx] <= rem_wr.data;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= regs_q[rd_idx];
    end
  end

endmodule // divide_shift_unit
`default_nettype wire

/* File: tb/divide_shift_checker.sv */
// checker: port timing of the divide and shift unit
`timescale 1ns/1ps
`default_nettype none
module divide_shift_checker (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic div_start,
  input wire logic div_busy,
  input wire logic div_done,
  input wire logic shift_start,
  input wire logic shift_done
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_div_latency: assert property (div_start && !div_busy |-> ##18 div_done)
    else $error("divide not done 18 cycles after start");
  a_busy_span: assert property (div_start && !div_busy |=> div_busy [*8])
    else $error("busy dropped early in divide");
  a_busy_hold: assert property (div_busy && !div_done |=> div_busy)
    else $error("busy fell before done");
  a_done_pulse: assert property (div_done |=> !div_done)
    else $error("done longer than one cycle");
  a_done_busy: assert property (div_done |-> div_busy)
    else $error("done outside busy");
  a_busy_release: assert property (div_done |=> !div_busy)
    else $error("busy stuck after done");
  a_shift_next: assert property (shift_start && !div_busy && !div_start |=> shift_done)
    else $error("shift not done in one cycle");
  a_shift_cause: assert property (shift_done |-> $past(shift_start && !div_busy && !div_start))
    else $error("shift done without accepted request");
endmodule // divide_shift_checker
bind divide_shift_unit divide_shift_checker chk (.core_clk(core_clk), .reset_n(reset_n),
  .div_start(div_start), .div_busy(div_busy), .div_done(div_done),
  .shift_start(shift_start), .shift_done(shift_done));
`default_nettype wire

/* File: tb/seq_model.sv */
// sequencer model: loads working registers and issues requests
`timescale 1ns/1ps
`default_nettype none
module seq_model (
  input  wire logic                core_clk,
  input  wire logic                div_done,
  output logic                     div_start,
  output divshift_pkg::div_req_s   div_req,
  output logic                     shift_start,
  output divshift_pkg::shift_req_s shift_req,
  output divshift_pkg::wr_port_s   seq_wr
);
  initial begin
    div_start = 1'b0;
    div_req = '0;
    shift_start = 1'b0;
    shift_req = '0;
    seq_wr = '0;
  end
  task automatic load(input logic [3:0] i, input logic [15:0] d);
    @(posedge core_clk) #1;
    seq_wr = '{1'b1, i, d};
    @(posedge core_clk) #1;
    seq_wr = '0;
  endtask
  // request stays put until done; divider captures its operands at the accepting edge
  task automatic divide(input divshift_pkg::div_req_s r);
    int n;
    @(posedge core_clk) #1;
    div_req = r;
    div_start = 1'b1;
    @(posedge core_clk) #1;
    div_start = 1'b0;
    for (n = 0; n < 30 && div_done !== 1'b1; n++) @(posedge core_clk) #1;
  endtask
  task automatic shift(input divshift_pkg::shift_req_s r);
    @(posedge core_clk) #1;
    shift_req = r;
    shift_start = 1'b1;
    @(posedge core_clk) #1;
    shift_start = 1'b0;
  endtask
endmodule // seq_model
`default_nettype wire

/* File: tb/integer_divide_and_shift_unit_tb_top.sv */
// testbench: divides, shifts and refused requests
`timescale 1ns/1ps
`default_nettype none
module integer_divide_and_shift_unit_tb_top;
  logic                       core_clk = 1'b0;
  logic                       reset_n = 1'b0;
  logic                       div_start, shift_start, div_busy, div_done, div_by_zero, shift_done;
  divshift_pkg::div_req_s     div_req;
  divshift_pkg::shift_req_s   shift_req;
  divshift_pkg::wr_port_s     seq_wr;
  logic [3:0]                 rd_idx = 4'h0;
  logic [15:0]                rd_data;
  int                         miscompares = 0;
  int                         checks = 0;
  always #5 core_clk = ~core_clk;
  divide_shift_unit uut (.core_clk(core_clk), .reset_n(reset_n), .div_start(div_start),
    .div_req(div_req), .div_busy(div_busy), .div_done(div_done), .div_by_zero(div_by_zero),
    .shift_start(shift_start), .shift_req(shift_req), .shift_done(shift_done),
    .seq_wr(seq_wr), .rd_idx(rd_idx), .rd_data(rd_data));
  seq_model p (.core_clk(core_clk), .div_done(div_done), .div_start(div_start),
    .div_req(div_req), .shift_start(shift_start), .shift_req(shift_req), .seq_wr(seq_wr));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd(input logic [3:0] i, input logic [15:0] exp);
    @(posedge core_clk) #1;
    rd_idx = i;
    @(posedge core_clk) #1;
    check($sformatf("reg %0d", i), rd_data, exp);
  endtask
  // dividend in pair 5:4, divisor in 3; narrow divides must ignore reg 5
  task automatic do_div(input logic w, s, input logic [15:0] hi, lo, dv, eq, er);
    p.load(4'h5, hi);
    p.load(4'h4, lo);
    p.load(4'h3, dv);
    p.divide('{w, s, (w ? 4'h5 : 4'h4), 4'h3});
    check("div_done", {15'h0000, div_done}, 16'h0001);
    rd(divshift_pkg::QUOT_REG, eq);
    rd(divshift_pkg::REM_REG, er);
    check("div_by_zero", {15'h0000, div_by_zero}, 16'h0000);
  endtask
  task automatic test_divide;
    do_div(1'b0, 1'b0, 16'hAAAA, 16'h0064, 16'h0007, 16'h000E, 16'h0002);
    do_div(1'b0, 1'b1, 16'h5555, 16'hFF9C, 16'h0007, 16'hFFF2, 16'hFFFE);
    do_div(1'b1, 1'b0, 16'h0001, 16'h0003, 16'h0010, 16'h1000, 16'h0003);
    do_div(1'b1, 1'b1, 16'hFFFE, 16'hFFFD, 16'h0010, 16'hF000, 16'hFFFD);
    do_div(1'b0, 1'b0, 16'h5555, 16'hFF9C, 16'h0007, 16'h2484, 16'h0000);
    do_div(1'b0, 1'b1, 16'h5555, 16'hFF9C, 16'hFFF9, 16'h000E, 16'hFFFE);
    do_div(1'b0, 1'b1, 16'h5555, 16'h0064, 16'hFFF9, 16'hFFF2, 16'h0002);
    p.load(4'h3, 16'h0000);
    p.divide('{1'b0, 1'b0, 4'h4, 4'h3});
    check("div_done", {15'h0000, div_done}, 16'h0001);
    @(posedge core_clk) #1;
    check("div_by_zero", {15'h0000, div_by_zero}, 16'h0001);
    $display("test_divide done");
  endtask
  task automatic test_shift;
    int o, k;
    logic [3:0] a;
    logic [15:0] expv [6];
    // by 1 and by 15: arithmetic right, logical right, left
    expv = '{16'hC210, 16'hFFFF, 16'h4210, 16'h0001, 16'h0842, 16'h8000};
    p.load(4'h6, 16'h8421);
    for (o = 0; o < 3; o++) for (k = 0; k < 2; k++) begin
      a = k ? 4'hF : 4'h1;
      p.shift('{divshift_pkg::shift_op_e'(o), a, 4'h6, 4'h7});
      rd(4'h7, expv[2*o+k]);
    end
    $display("test_shift done");
  endtask
  // a shift offered mid-divide is refused, so its destination keeps its value
  task automatic test_refused;
    p.load(4'h8, 16'h1234);
    fork
      p.divide('{1'b0, 1'b0, 4'h4, 4'h3});
      begin
        repeat (3) @(posedge core_clk);
        p.shift('{divshift_pkg::SHIFT_LEFT, 4'h1, 4'h6, 4'h8});
      end
    join
    rd(4'h8, 16'h1234);
    $display("test_refused done");
  endtask
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    #1 reset_n = 1'b1;
    rd(divshift_pkg::QUOT_REG, 16'h0000);
    test_divide;
    test_shift;
    test_refused;
    end_of_test;
  end
  initial begin
    #100000;
    miscompares++;
    end_of_test;
  end
endmodule // integer_divide_and_shift_unit_tb_top
`default_nettype wire
